// File: rtl/tmc_regs.vh
// register offsets, field positions and reset values of the timer control block
`ifndef TMC_REGS_VH
`define TMC_REGS_VH
// ****************************************************************
// register offsets
// ****************************************************************
`define TMC_ADDR_TSC 3'h0
`define TMC_ADDR_CNT_HI 3'h1
`define TMC_ADDR_CNT_LO 3'h2
`define TMC_ADDR_MOD_HI 3'h3
`define TMC_ADDR_MOD_LO 3'h4
`define TMC_ADDR_CH0 3'h5
`define TMC_ADDR_CH1 3'h6
// ****************************************************************
// field positions
// ****************************************************************
`define TMC_TSC_OVF 7
`define TMC_TSC_OVIE 6
`define TMC_TSC_HALT 5
`define TMC_TSC_CRST 4
`define TMC_CH_FLAG 7
`define TMC_CH_IE 6
`define TMC_CH_MSB 5
`define TMC_CH_MSA 4
`define TMC_CH_ELSB 3
`define TMC_CH_ELSA 2
// ****************************************************************
// edge/level codes and reset values
// ****************************************************************
`define TMC_ELS_OFF 2'h0
`define TMC_ELS_RISE 2'h1
`define TMC_ELS_FALL 2'h2
`define TMC_ELS_BOTH 2'h3
`define TMC_MOD_RST 16'hFFFF
`define TMC_CNT_RST 16'h0000
`define TMC_CH_VAL_RST 16'hFFFF
`endif

// File: rtl/tmc_timer.v
// timer overflow control and two capture/compare channels with register port
//
// Implementation choices: strobed register access and the register offsets.
`include "tmc_regs.vh"

module tmc_timer
#(
    parameter PRESCALE = 1,
    parameter NCH = 2
)
(
    // clock and reset
    input wire clk_i,
    input wire nrst_i,
    // register port
    input wire [2:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    // modulo and channel value registers, loaded elsewhere
    input wire [15:0] mod_i,
    input wire [16*NCH-1:0] ch_val_i,
    // channel pins
    input wire [NCH-1:0] channel_pin_i,
    output wire [NCH-1:0] channel_pin_o,
    output wire [NCH-1:0] channel_pin_oe_o,
    // status
    output wire [15:0] count_o,
    output wire overflow_irq_o,
    output wire [NCH-1:0] channel_irq_o
);

// ****************************************************************
// timer status and counter
// ****************************************************************
reg overflow_flag_reg;
reg overflow_irq_enable_reg;
reg counter_halt_reg;
reg ovf_armed_reg;
reg [15:0] count_reg;
reg [15:0] pre_reg;
wire tick;
wire at_mod;
wire ovf_evt;
wire tsc_wr;
wire tsc_rd;
wire crst;

assign tsc_wr = wr_i && (addr_i == `TMC_ADDR_TSC);
assign tsc_rd = rd_i && (addr_i == `TMC_ADDR_TSC);
assign crst = tsc_wr && wdata_i[`TMC_TSC_CRST];
assign tick = !counter_halt_reg && (pre_reg == PRESCALE - 1);
assign at_mod = (count_reg == mod_i);
assign ovf_evt = tick && at_mod;
assign count_o = count_reg;

always @(posedge clk_i)
begin
    if (!nrst_i)
    begin
        pre_reg <= 16'h0000;
        count_reg <= `TMC_CNT_RST;
    end
    else if (crst)
    begin
        // counter reset wins over halt, so both together park at zero
        pre_reg <= 16'h0000;
        count_reg <= `TMC_CNT_RST;
    end
    else if (!counter_halt_reg)
    begin
        if (pre_reg == PRESCALE - 1)
        begin
            pre_reg <= 16'h0000;
            count_reg <= at_mod ? `TMC_CNT_RST : count_reg + 16'h0001;
        end
        else
        begin
            pre_reg <= pre_reg + 16'h0001;
        end
    end
end

always @(posedge clk_i)
begin
    if (!nrst_i)
    begin
        overflow_flag_reg <= 1'b0;
        overflow_irq_enable_reg <= 1'b0;
        counter_halt_reg <= 1'b1;
        ovf_armed_reg <= 1'b0;
    end
    else
    begin
        if (tsc_wr)
        begin
            overflow_irq_enable_reg <= wdata_i[`TMC_TSC_OVIE];
            counter_halt_reg <= wdata_i[`TMC_TSC_HALT];
        end
        // set beats clear; an event also disarms the pending clear
        if (ovf_evt)
        begin
            overflow_flag_reg <= 1'b1;
            ovf_armed_reg <= 1'b0;
        end
        else if (tsc_wr && !wdata_i[`TMC_TSC_OVF] && ovf_armed_reg)
        begin
            overflow_flag_reg <= 1'b0;
            ovf_armed_reg <= 1'b0;
        end
        else if (tsc_rd && overflow_flag_reg)
        begin
            ovf_armed_reg <= 1'b1;
        end
    end
end

assign overflow_irq_o = overflow_flag_reg && overflow_irq_enable_reg;

// ****************************************************************
// pin input synchronisers
// ****************************************************************
reg [NCH-1:0] pin_s1_reg;
reg [NCH-1:0] pin_s2_reg;
reg [NCH-1:0] pin_s3_reg;
reg [NCH-1:0] pin_lvl_reg;

always @(posedge clk_i)
begin
    if (!nrst_i)
    begin
        pin_s1_reg <= {NCH{1'b0}};
        pin_s2_reg <= {NCH{1'b0}};
        pin_s3_reg <= {NCH{1'b0}};
        pin_lvl_reg <= {NCH{1'b0}};
    end
    else
    begin
        pin_s1_reg <= channel_pin_i;
        pin_s2_reg <= pin_s1_reg;
        pin_s3_reg <= pin_s2_reg;
        // accept a new level only once stages two and three agree
        pin_lvl_reg <= (pin_s2_reg & pin_s3_reg) | (pin_lvl_reg & (pin_s2_reg | pin_s3_reg));
    end
end

// ****************************************************************
// channels
// ****************************************************************
reg [NCH-1:0] ch_flag_reg;
reg [NCH-1:0] ch_ie_reg;
reg [NCH-1:0] ch_msa_reg;
reg [NCH-1:0] ch_armed_reg;
reg [1:0] ch_els_reg [0:NCH-1];
reg [NCH-1:0] ch_out_reg;
reg [NCH-1:0] lvl_d_reg;
reg ch0_buffered_reg;
wire [NCH-1:0] ch_active;

always @(posedge clk_i)
begin
    if (!nrst_i)
    begin
        ch0_buffered_reg <= 1'b0;
        lvl_d_reg <= {NCH{1'b0}};
    end
    else
    begin
        lvl_d_reg <= pin_lvl_reg;
        if (wr_i && (addr_i == `TMC_ADDR_CH0))
        begin
            ch0_buffered_reg <= wdata_i[`TMC_CH_MSB];
        end
    end
end

genvar g;
generate
for (g = 0; g < NCH; g = g + 1)
begin : g_ch
    wire sel_wr;
    wire sel_rd;
    wire rise;
    wire fall;
    wire cap_hit;
    wire cmp_hit;
    wire evt;
    wire is_cmp;
    assign sel_wr = wr_i && (addr_i == `TMC_ADDR_CH0 + g);
    assign sel_rd = rd_i && (addr_i == `TMC_ADDR_CH0 + g);
    // channel one is ignored while channel zero runs buffered
    assign ch_active[g] = !(g == 1 && ch0_buffered_reg)
        && (ch_els_reg[g] != `TMC_ELS_OFF);
    assign is_cmp = ch_msa_reg[g] || (g == 0 && ch0_buffered_reg);
    assign rise = pin_lvl_reg[g] && !lvl_d_reg[g];
    assign fall = !pin_lvl_reg[g] && lvl_d_reg[g];
    assign cap_hit = ((ch_els_reg[g] == `TMC_ELS_RISE) && rise)
        || ((ch_els_reg[g] == `TMC_ELS_FALL) && fall)
        || ((ch_els_reg[g] == `TMC_ELS_BOTH) && (rise || fall));
    assign cmp_hit = tick && (count_reg == ch_val_i[16*g +: 16]);
    // captures need a running counter
    assign evt = ch_active[g] && (is_cmp ? cmp_hit : (cap_hit && !counter_halt_reg));
    assign channel_irq_o[g] = ch_flag_reg[g] && ch_ie_reg[g];
    assign channel_pin_oe_o[g] = ch_active[g] && is_cmp;
    assign channel_pin_o[g] = ch_out_reg[g];

    always @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            ch_flag_reg[g] <= 1'b0;
            ch_ie_reg[g] <= 1'b0;
            ch_msa_reg[g] <= 1'b0;
            ch_armed_reg[g] <= 1'b0;
            ch_els_reg[g] <= `TMC_ELS_OFF;
            ch_out_reg[g] <= 1'b1;
        end
        else
        begin
            if (sel_wr)
            begin
                ch_ie_reg[g] <= wdata_i[`TMC_CH_IE];
                ch_msa_reg[g] <= wdata_i[`TMC_CH_MSA];
                ch_els_reg[g] <= wdata_i[`TMC_CH_ELSB:`TMC_CH_ELSA];
            end
            if (evt)
            begin
                ch_flag_reg[g] <= 1'b1;
                ch_armed_reg[g] <= 1'b0;
            end
            else if (sel_wr && !wdata_i[`TMC_CH_FLAG] && ch_armed_reg[g])
            begin
                ch_flag_reg[g] <= 1'b0;
                ch_armed_reg[g] <= 1'b0;
            end
            else if (sel_rd && ch_flag_reg[g])
            begin
                ch_armed_reg[g] <= 1'b1;
            end
            // pin level: preset while disconnected, action on a match
            if (ch_els_reg[g] == `TMC_ELS_OFF)
            begin
                ch_out_reg[g] <= !ch_msa_reg[g];
            end
            else if (ch_active[g] && is_cmp && cmp_hit)
            begin
                // the same edge code means a pin action once the channel compares
                case (ch_els_reg[g])
                    `TMC_ELS_RISE:
                    begin
                        ch_out_reg[g] <= !ch_out_reg[g];
                    end
                    `TMC_ELS_FALL:
                    begin
                        ch_out_reg[g] <= 1'b0;
                    end
                    `TMC_ELS_BOTH:
                    begin
                        ch_out_reg[g] <= 1'b1;
                    end
                    default:
                    begin
                        ch_out_reg[g] <= ch_out_reg[g];
                    end
                endcase
            end
        end
    end
end
endgenerate

// ****************************************************************
// read data, one cycle after the strobe
// ****************************************************************
function [7:0] ch_byte;
    input flag;
    input ie;
    input msb;
    input msa;
    input [1:0] els;
    begin
        ch_byte = {flag, ie, msb, msa, els, 2'h0};
    end
endfunction

always @(posedge clk_i)
begin
    if (!nrst_i)
    begin
        rdata_o <= 8'h00;
    end
    else if (rd_i)
    begin
        case (addr_i)
            // counter reset bit always reads 0
            `TMC_ADDR_TSC:
            begin
                rdata_o <= {overflow_flag_reg, overflow_irq_enable_reg,
                    counter_halt_reg, 5'h00};
            end
            // count bytes are not latched as a pair; software reads hi then lo
            `TMC_ADDR_CNT_HI:
            begin
                rdata_o <= count_reg[15:8];
            end
            `TMC_ADDR_CNT_LO:
            begin
                rdata_o <= count_reg[7:0];
            end
            // modulo is a read-only mirror; its writable copy lives outside
            `TMC_ADDR_MOD_HI:
            begin
                rdata_o <= mod_i[15:8];
            end
            `TMC_ADDR_MOD_LO:
            begin
                rdata_o <= mod_i[7:0];
            end
            `TMC_ADDR_CH0:
            begin
                rdata_o <= ch_byte(ch_flag_reg[0], ch_ie_reg[0],
                    ch0_buffered_reg, ch_msa_reg[0], ch_els_reg[0]);
            end
            // buffered select exists only on channel zero, so reads 0 here
            `TMC_ADDR_CH1:
            begin
                rdata_o <= ch_byte(ch_flag_reg[NCH-1], ch_ie_reg[NCH-1],
                    1'b0, ch_msa_reg[NCH-1], ch_els_reg[NCH-1]);
            end
            default:
            begin
                rdata_o <= 8'h00;
            end
        endcase
    end
    else
    begin
        rdata_o <= 8'h00;
    end
end

endmodule // tmc_timer

// File: tb/testbench.sv
// self-checking bench of the timer control block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    reg clk_i = 1'b0;
    reg nrst_i = 1'b0;
    reg [2:0] addr_i = 3'h0;
    reg [7:0] wdata_i = 8'h00;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    reg [15:0] mod_i = 16'h0020;
    reg [31:0] ch_val_i = 32'h0008_0000;
    reg [1:0] src = 2'h0;
    reg [1:0] els;
    wire [7:0] rdata_o;
    wire [1:0] lvl, pin_o, oe_o, chirq;
    wire [15:0] count_o;
    wire ovirq;
    integer fails = 0;
    integer compares = 0;
    integer i;
    always #50 clk_i = ~clk_i;
    tmc_timer #(.PRESCALE(1), .NCH(2)) dut (.clk_i(clk_i), .nrst_i(nrst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .mod_i(mod_i), .ch_val_i(ch_val_i), .channel_pin_i(lvl), .channel_pin_o(pin_o),
        .channel_pin_oe_o(oe_o), .count_o(count_o), .overflow_irq_o(ovirq),
        .channel_irq_o(chirq));
    tmc_pin_model u_pin (.src_i(src), .drv_i(pin_o), .oe_i(oe_o), .pin_lvl_o(lvl));
    task chk(input [47:0] nm, input [15:0] e, input [15:0] g);
        begin
            compares = compares + 1;
            if (g !== e)
            begin
                fails = fails + 1;
                $display("mismatch %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task idle(input integer n);
        begin
            repeat (n) @(posedge clk_i);
            #1;
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge clk_i);
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
            @(posedge clk_i);
            wr_i <= 1'b0;
        end
    endtask
    task rd(input [2:0] a, input [7:0] e);
        begin
            @(posedge clk_i);
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge clk_i);
            rd_i <= 1'b0;
            #1 chk("rdata", {8'h00, e}, {8'h00, rdata_o});
        end
    endtask
    // pin edges pass a synchroniser, so give them time to land
    task pin(input [1:0] v);
        begin
            @(posedge clk_i);
            src <= v;
            idle(8);
        end
    endtask
    task results;
        begin
            $display("compares %0d fails %0d", compares, fails);
            if (fails == 0 && compares > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    initial
    begin
        #400000;
        fails = fails + 1;
        results;
    end
    initial
    begin
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(3'h0, 8'h20);
        idle(5);
        chk("count", 16'h0000, count_o);
        rd(3'h7, 8'h00);
        wr(3'h7, 8'hFF);
        rd(3'h0, 8'h20);
        $display("test reset done");
        wr(3'h0, 8'h10);
        idle(40);
        chk("ovirq", 16'h0000, {15'h0, ovirq});
        rd(3'h0, 8'h80);
        wr(3'h0, 8'h80);
        rd(3'h0, 8'h80);
        wr(3'h0, 8'h00);
        rd(3'h0, 8'h00);
        wr(3'h0, 8'h10);
        idle(40);
        rd(3'h0, 8'h80);
        idle(30);
        wr(3'h0, 8'h00);
        rd(3'h0, 8'h80);
        wr(3'h0, 8'h50);
        idle(40);
        chk("ovirq", 16'h0001, {15'h0, ovirq});
        rd(3'h0, 8'hC0);
        wr(3'h0, 8'h40);
        rd(3'h0, 8'h40);
        chk("ovirq", 16'h0000, {15'h0, ovirq});
        wr(3'h0, 8'h30);
        idle(5);
        chk("count", 16'h0000, count_o);
        $display("test overflow done");
        wr(3'h5, 8'h04);
        pin(2'h1);
        rd(3'h5, 8'h04);
        pin(2'h0);
        for (i = 1; i < 4; i = i + 1)
        begin
            els = i[1:0];
            wr(3'h0, 8'h30);
            wr(3'h5, {4'h4, els, 2'h0});
            wr(3'h0, 8'h00);
            pin(2'h1);
            chk("chirq", {15'h0, els != 2'h2}, {15'h0, chirq[0]});
            rd(3'h5, {els != 2'h2, 3'h4, els, 2'h0});
            wr(3'h5, {4'h4, els, 2'h0});
            pin(2'h0);
            rd(3'h5, {els != 2'h1, 3'h4, els, 2'h0});
            wr(3'h5, {4'h4, els, 2'h0});
            rd(3'h5, {4'h4, els, 2'h0});
        end
        $display("test capture done");
        wr(3'h0, 8'h30);
        wr(3'h6, 8'h14);
        wr(3'h0, 8'h10);
        idle(20);
        rd(3'h6, 8'h94);
        chk("chirq1", 16'h0000, {15'h0, chirq[1]});
        wr(3'h6, 8'h14);
        rd(3'h6, 8'h14);
        wr(3'h0, 8'h20);
        idle(3);
        chk("count", 16'h0000, (count_o == 16'h0000) ? 16'h0001 : 16'h0000);
        chk("oe1", 16'h0001, {15'h0, oe_o[1]});
        wr(3'h0, 8'h30);
        wr(3'h5, 8'h20);
        idle(1);
        chk("oe1", 16'h0000, {15'h0, oe_o[1]});
        wr(3'h5, 8'h00);
        idle(1);
        chk("oe0", 16'h0000, {15'h0, oe_o[0]});
        wr(3'h6, 8'h10);
        idle(1);
        chk("pin1", 16'h0000, {15'h0, pin_o[1]});
        chk("oe1", 16'h0000, {15'h0, oe_o[1]});
        wr(3'h6, 8'h00);
        idle(1);
        chk("pin1", 16'h0001, {15'h0, pin_o[1]});
        $display("test modes done");
        results;
    end
endmodule // testbench

// File: tb/tmc_pin_model.sv
// far-side pin model: an outside signal source that yields where the block drives
module tmc_pin_model
(
    input wire [1:0] src_i,
    input wire [1:0] drv_i,
    input wire [1:0] oe_i,
    output wire [1:0] pin_lvl_o
);
    timeunit 1ns;
    timeprecision 1ns;
    assign pin_lvl_o = (oe_i & drv_i) | (~oe_i & src_i);
endmodule // tmc_pin_model

// File: tb/tmc_timer_properties.sv
// port-level checks of the timer control block
module tmc_timer_properties
#(
    parameter PRESCALE = 1,
    parameter NCH = 2
)
(
    input wire clk_i,
    input wire nrst_i,
    input wire [2:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire [15:0] mod_i,
    input wire [NCH-1:0] channel_pin_oe_o,
    input wire [15:0] count_o,
    input wire overflow_irq_o,
    input wire [NCH-1:0] channel_irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    reg halt_reg;
    wire tsc_wr = wr_i && addr_i == 3'h0;
    // shadow of the halt bit: only register writes move it
    always @(posedge clk_i)
        if (!nrst_i) halt_reg <= 1'b1;
        else if (tsc_wr) halt_reg <= wdata_i[5];
    // ********************
    // properties
    // ********************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_park;
        count_o == 16'h0000 ##1 count_o == 16'h0000;
    endsequence
    chk_halt_freeze: assert property (halt_reg && !tsc_wr |=> $stable(count_o))
        else $error("counter moved while halted");
    chk_count_step: assert property (!halt_reg && !tsc_wr && count_o != mod_i
        |=> count_o == $past(count_o) + 16'h0001) else $error("counter did not step");
    chk_count_wrap: assert property (!halt_reg && !tsc_wr && count_o == mod_i
        |=> count_o == 16'h0000) else $error("counter did not wrap");
    chk_crst_zero: assert property (tsc_wr && wdata_i[4] |=> count_o == 16'h0000)
        else $error("counter reset ignored");
    chk_crst_read: assert property ($past(rd_i && addr_i == 3'h0) |-> !rdata_o[4])
        else $error("counter reset bit read as one");
    chk_halt_park: assert property (tsc_wr && wdata_i[5:4] == 2'h3 |=> s_park)
        else $error("counter not parked at zero");
    chk_ovf_rise: assert property ($rose(overflow_irq_o)
        |-> $past(count_o == mod_i || tsc_wr)) else $error("overflow request without cause");
    chk_ovf_fall: assert property ($fell(overflow_irq_o) |-> $past(tsc_wr))
        else $error("overflow request dropped without write");
    chk_buf_frees: assert property (wr_i && addr_i == 3'h5 && wdata_i[5]
        |=> !channel_pin_oe_o[1]) else $error("buffered mode kept second pin");
    chk_oe_release: assert property (wr_i && addr_i == 3'h5 && wdata_i[5:2] == 4'h0
        |=> !channel_pin_oe_o[0]) else $error("pin still driven");
    chk_chirq_fall: assert property ($fell(channel_irq_o[0]) |-> $past(wr_i))
        else $error("channel request dropped without write");
endmodule // tmc_timer_properties
bind tmc_timer tmc_timer_properties #(.PRESCALE(PRESCALE), .NCH(NCH)) u_chk (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .mod_i(mod_i), .channel_pin_oe_o(channel_pin_oe_o),
    .count_o(count_o), .overflow_irq_o(overflow_irq_o), .channel_irq_o(channel_irq_o));
